// ==== common/hubg_regs.vh ====
// register map, field positions, reset values and timing figures of the host uart
`ifndef HUBG_REGS_VH
`define HUBG_REGS_VH
// register indices; byte address on the bus is four times the index
`define HUBG_SPEED_IDX     8'h3B
`define HUBG_DATA_IDX      8'h3C
`define HUBG_STAT_IDX      8'h3D
// reset values
`define HUBG_SPEED_RST     8'h7A
// speed register fields
`define HUBG_EXP_MSB       7
`define HUBG_EXP_LSB       5
`define HUBG_MANT_MSB      4
`define HUBG_MANT_LSB      0
// divisor offsets of the two speed modes
`define HUBG_MANT_OFS_LO   6'h01
`define HUBG_MANT_OFS_HI   6'h21
// status register bits
`define HUBG_ST_TXBUSY     0
`define HUBG_ST_RXVALID    1
`define HUBG_ST_OVERRUN    2
`define HUBG_ST_FRAMEERR   3
// timing: reference crystal and system clock in kHz, oversampling per bit
`define HUBG_REF_KHZ       27120
`define HUBG_CLK_PERIOD_PS 25000
`define HUBG_CLK_KHZ       (1000000000 / `HUBG_CLK_PERIOD_PS)
`define HUBG_OVS           16
`define HUBG_CHAR_BITS     8
`endif

// ==== core/hubg_tick.v ====
// oversampling tick generator for the serial bit rate
`timescale 1ns/1ps
`default_nettype none
`include "hubg_regs.vh"
module hubg_tick #(
  parameter integer REF_KHZ = `HUBG_REF_KHZ, // reference crystal rate
  parameter integer CLK_KHZ = `HUBG_CLK_KHZ, // system clock rate
  parameter integer OVS     = `HUBG_OVS      // ticks per bit
) (
  input  wire       clk,      // system clock
  input  wire       rstn,     // synchronous reset, active low
  input  wire       ce,       // clock enable, freezes state when low
  input  wire [2:0] exponent, // baud_exponent field
  input  wire [4:0] mantissa, // baud_mantissa field
  output reg        tick_r    // one-cycle oversampling tick
);
  localparam [31:0] REF_STEP = REF_KHZ;          // reference cycles per clk, scaled
  localparam [31:0] CLK_UNIT = CLK_KHZ / OVS;    // clk share of one oversample

  reg  [12:0] divisor;  // reference cycles per bit
  reg  [31:0] acc_r;    // fractional phase accumulator
  reg  [31:0] acc_sum;  // accumulator plus one step
  reg  [31:0] acc_rem;  // remainder after a tick
  wire [31:0] thresh;   // reference-scaled length of one oversample

  // divisor of the reference clock from the two speed fields
  always @* begin
    if (exponent == 3'h0) begin
      divisor = {7'h00, {1'b0, mantissa} + `HUBG_MANT_OFS_LO};
    end else begin
      // seven bits: mantissa 31 plus 33 is 64 and must not wrap to zero
      divisor = {6'h00, {2'b00, mantissa} + {1'b0, `HUBG_MANT_OFS_HI}} << (exponent - 3'h1);
    end
  end

  assign thresh = {19'h00000, divisor} * CLK_UNIT;

  // next accumulator value, compared against one oversample period
  always @* begin
    acc_sum = acc_r + REF_STEP;
    acc_rem = acc_sum - thresh;
  end

  // accumulator: a fractional divider keeps the mean rate exact although
  // the system clock is no multiple of the crystal; jitter is one clk cycle
  always @(posedge clk) begin
    if (!rstn) begin
      acc_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (ce) begin
      if (acc_sum >= thresh) begin
        tick_r <= 1'b1;
        // rates too fast for one tick per clk saturate instead of drifting
        acc_r  <= (acc_rem >= thresh) ? 32'h00000000 : acc_rem;
      end else begin
        tick_r <= 1'b0;
        acc_r  <= acc_sum;
      end
    end
  end
endmodule // hubg_tick
`default_nettype wire

// ==== core/hubg_uart.v ====
// host serial uart with programmable bit rate and avalon-mm register access
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hubg_regs.vh"
module hubg_uart #(
  parameter integer OVS = `HUBG_OVS // oversampling ticks per bit
) (
  input  wire        clk,             // system clock, 40 mhz
  input  wire        rstn,            // synchronous reset, active low
  input  wire        ce,              // clock enable, freezes all state when low
  input  wire [7:0]  avs_address,     // byte address
  input  wire        avs_read,        // read request
  input  wire        avs_write,       // write request
  input  wire [31:0] avs_writedata,   // write data
  output reg  [31:0] avs_readdata,    // read data
  output reg         avs_waitrequest, // stall until answer
  input  wire        rxd,             // serial input from the host
  output reg         txd_r            // serial output to the host
);
  localparam integer TICK_LAST_I = OVS - 1;          // last tick of a bit, full width
  localparam integer TICK_MID_I  = (OVS / 2) - 1;    // middle tick, full width
  localparam integer CHAR_BITS_I = `HUBG_CHAR_BITS;  // data bits, full width
  // cut to the 4-bit counters; an OVS above 16 would need wider counters
  localparam [3:0]   TICK_LAST   = TICK_LAST_I[3:0]; // last tick of a bit
  localparam [3:0]   TICK_MID    = TICK_MID_I[3:0];  // tick at the middle of a bit
  localparam [3:0]   CHAR_BITS   = CHAR_BITS_I[3:0]; // data bits per character

  // receiver states
  localparam [1:0] RX_IDLE  = 2'b00;
  localparam [1:0] RX_START = 2'b01;
  localparam [1:0] RX_DATA  = 2'b10;
  localparam [1:0] RX_STOP  = 2'b11;

  // registers
  reg  [7:0] speed_r;     // serial_bit_rate register
  reg  [7:0] rx_data_r;   // last received character
  reg        rx_valid_r;  // character waiting to be read
  reg        overrun_r;   // character lost, sticky
  reg        frame_err_r; // stop bit found low, sticky

  // bus decode
  wire       req;       // read or write pending
  wire       ack;       // answer edge of the current request
  wire [7:0] word_idx;  // register index from byte address
  wire       hit_speed; // speed register addressed
  wire       hit_data;  // data register addressed
  wire       hit_stat;  // status register addressed

  // synchroniser and tick
  reg        rxd_s1_r;  // first sync stage
  reg        rxd_s2_r;  // second sync stage
  reg        rxd_s3_r;  // previous synced value for edge detection
  wire       tick;      // oversampling tick

  // transmitter
  reg        tx_busy_r; // character in flight
  reg  [8:0] tx_sh_r;   // remaining bits, stop bit on top
  reg  [3:0] tx_left_r; // bits still to send after the current one
  reg  [3:0] tx_cnt_r;  // tick counter within a bit

  // receiver
  reg  [1:0] rx_st_r;   // receiver state
  reg  [3:0] rx_cnt_r;  // tick counter within a bit
  reg  [3:0] rx_bits_r; // data bits received
  reg  [7:0] rx_sh_r;   // receive shift register

  // status and readback
  wire [7:0] status;    // status register view
  reg  [7:0] rd_mux;    // read data of the addressed register
  wire       tx_load;   // accepted write to the data register
  wire       rx_done;   // stop bit sampled
  wire       rx_take;   // accepted read of the data register
  wire       stat_clr;  // accepted write to the status register

  assign req       = avs_read | avs_write;
  assign ack       = req & ~avs_waitrequest;
  assign word_idx  = {2'b00, avs_address[7:2]};
  assign hit_speed = (word_idx == `HUBG_SPEED_IDX);
  assign hit_data  = (word_idx == `HUBG_DATA_IDX);
  assign hit_stat  = (word_idx == `HUBG_STAT_IDX);
  assign tx_load   = ack & avs_write & hit_data & ~tx_busy_r;
  assign rx_take   = ack & avs_read & hit_data;
  assign stat_clr  = ack & avs_write & hit_stat;
  assign rx_done   = tick & (rx_st_r == RX_STOP) & (rx_cnt_r == TICK_LAST);

  assign status = {4'h0, frame_err_r, overrun_r, rx_valid_r, tx_busy_r};

  // bit-rate tick from the speed register fields
  hubg_tick #(
    .OVS (OVS)
  ) u_tick (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .exponent (speed_r[`HUBG_EXP_MSB:`HUBG_EXP_LSB]),
    .mantissa (speed_r[`HUBG_MANT_MSB:`HUBG_MANT_LSB]),
    .tick_r   (tick)
  );

  // read multiplexer; unmapped addresses read as zero
  always @* begin
    case (word_idx)
      `HUBG_SPEED_IDX: rd_mux = speed_r;
      `HUBG_DATA_IDX:  rd_mux = rx_data_r;
      `HUBG_STAT_IDX:  rd_mux = status;
      default:         rd_mux = 8'h00;
    endcase
  end

  // bus answer: waitrequest drops for one cycle, the cycle after the request
  // is seen; read data are captured together so they stand at the answer edge
  always @(posedge clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (ce) begin
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h000000, rd_mux};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // speed register; writes take effect at the answer edge
  always @(posedge clk) begin
    if (!rstn) begin
      speed_r <= `HUBG_SPEED_RST;
    end else if (ce) begin
      if (ack & avs_write & hit_speed) begin
        speed_r <= avs_writedata[7:0];
      end
    end
  end

  // rxd pin crossing: two stages, then an edge-detect stage off the second
  always @(posedge clk) begin
    if (!rstn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      rxd_s3_r <= 1'b1;
    end else if (ce) begin
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
      rxd_s3_r <= rxd_s2_r;
    end
  end

  // transmitter: a write while busy is dropped, software polls tx busy
  always @(posedge clk) begin
    if (!rstn) begin
      txd_r     <= 1'b1;
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 9'h1FF;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= 4'h0;
    end else if (ce) begin
      if (tx_load) begin
        // start bit goes out at once, then data lsb first, then the stop bit
        txd_r     <= 1'b0;
        tx_sh_r   <= {1'b1, avs_writedata[7:0]};
        tx_left_r <= CHAR_BITS + 4'h1;
        tx_cnt_r  <= 4'h0;
        tx_busy_r <= 1'b1;
      end else if (tx_busy_r & tick) begin
        if (tx_cnt_r == TICK_LAST) begin
          tx_cnt_r <= 4'h0;
          if (tx_left_r != 4'h0) begin
            txd_r     <= tx_sh_r[0];
            tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
            tx_left_r <= tx_left_r - 4'h1;
          end else begin
            // stop bit has lasted a full period; line stays high
            tx_busy_r <= 1'b0;
          end
        end else begin
          tx_cnt_r <= tx_cnt_r + 4'h1;
        end
      end
    end
  end

  // receiver state machine
  always @(posedge clk) begin
    if (!rstn) begin
      rx_st_r   <= RX_IDLE;
      rx_cnt_r  <= 4'h0;
      rx_bits_r <= 4'h0;
      rx_sh_r   <= 8'h00;
    end else if (ce) begin
      case (rx_st_r)
        RX_IDLE: begin
          // falling edge of the line marks a start bit
          if (rxd_s3_r & ~rxd_s2_r) begin
            rx_st_r  <= RX_START;
            rx_cnt_r <= 4'h0;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_cnt_r == TICK_MID) begin
              // a glitch shorter than half a bit is not a start bit
              rx_st_r   <= rxd_s2_r ? RX_IDLE : RX_DATA;
              rx_cnt_r  <= 4'h0;
              rx_bits_r <= 4'h0;
            end else begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (rx_cnt_r == TICK_LAST) begin
              // one full bit after the middle is the middle of the next bit
              rx_cnt_r  <= 4'h0;
              rx_sh_r   <= {rxd_s2_r, rx_sh_r[7:1]};
              rx_bits_r <= rx_bits_r + 4'h1;
              if (rx_bits_r == CHAR_BITS - 4'h1) begin
                rx_st_r <= RX_STOP;
              end
            end else begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            if (rx_cnt_r == TICK_LAST) begin
              rx_st_r  <= RX_IDLE;
              rx_cnt_r <= 4'h0;
            end else begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // received character and sticky flags; a hardware set wins over any clear
  // in the same cycle so no event is lost
  always @(posedge clk) begin
    if (!rstn) begin
      rx_data_r   <= 8'h00;
      rx_valid_r  <= 1'b0;
      overrun_r   <= 1'b0;
      frame_err_r <= 1'b0;
    end else if (ce) begin
      if (rx_done) begin
        // no parity bit exists, only the stop bit is checked
        rx_data_r  <= rx_sh_r;
        rx_valid_r <= 1'b1;
      end else if (rx_take) begin
        rx_valid_r <= 1'b0;
      end
      if (rx_done & rx_valid_r & ~rx_take) begin
        overrun_r <= 1'b1;
      end else if (stat_clr & avs_writedata[`HUBG_ST_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
      if (rx_done & ~rxd_s2_r) begin
        frame_err_r <= 1'b1;
      end else if (stat_clr & avs_writedata[`HUBG_ST_FRAMEERR]) begin
        frame_err_r <= 1'b0;
      end
    end
  end
endmodule // hubg_uart
`default_nettype wire

// ==== dv/hubg_host_model.sv ====
// behavioural host uart facing the serial pins
`timescale 1ns/1ps
`default_nettype none
module hubg_host_model (
  input  wire logic txd, // device serial output
  output var  logic rxd  // device serial input
);
  realtime t_fall; // last falling edge of txd
  realtime t_rise; // last rising edge of txd
  initial rxd = 1'b1; // mark level between characters
  always @(negedge txd) t_fall = $realtime;
  always @(posedge txd) t_rise = $realtime;
  // send one character; a low stop level forces a framing fault
  task automatic send(input logic [7:0] d, input logic stp, input real t);
    rxd = 1'b0; // start bit
    #(t);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i]; // lsb first, no parity
      #(t);
    end
    rxd = stp;
    #(t);
    rxd = 1'b1; // one idle bit so the next start edge is clean
    #(t);
  endtask
  // take one character, sampling each bit near its middle
  task automatic recv(input real t, output logic [7:0] d, output logic stp);
    @(negedge txd);
    #(t / 2);
    for (int i = 0; i < 8; i++) begin
      #(t);
      d[i] = txd;
    end
    #(t);
    stp = txd;
  endtask
endmodule // hubg_host_model
`default_nettype wire

// ==== dv/hubg_props.sv ====
// port checker for the host uart, bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module hubg_props #(
  parameter integer OVS = 16 // ticks per bit
) (
  input wire logic        clk,             // system clock
  input wire logic        rstn,            // sync reset, active low
  input wire logic        ce,              // clock enable
  input wire logic [7:0]  avs_address,     // byte address
  input wire logic        avs_read,        // read request
  input wire logic        avs_write,       // write request
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest, // stall
  input wire logic        rxd,             // serial in, not checked here
  input wire logic        txd_r            // serial out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0]  spd_r; // speed as last written
  logic        wr_r;  // speed written since reset
  logic [15:0] low_r; // cycles txd has been low
  int          per;   // bit period in clocks
  // bit period from the tracked setting; a mid-frame change would void the bound
  always_comb begin
    // rounded up so the bound never undercuts the real period
    if (spd_r[7:5] == 3'h0) per = ((int'(spd_r[4:0]) + 1) * 40000 + 27119) / 27120;
    else per = (((int'(spd_r[4:0]) + 33) << (spd_r[7:5] - 1)) * 40000 + 27119) / 27120;
  end
  // follow speed writes and low runs of the serial output
  always_ff @(posedge clk) begin
    if (!rstn) begin
      spd_r <= 8'h7A;
      wr_r  <= 1'b0;
      low_r <= 16'h0;
    end else begin
      if (ce && !avs_waitrequest && avs_write && avs_address == 8'hEC) begin
        spd_r <= avs_writedata[7:0];
        wr_r  <= 1'b1;
      end
      // frozen cycles are not counted, the line is held on purpose then
      low_r <= txd_r ? 16'h0 : (ce ? low_r + 16'h1 : low_r);
    end
  end
  sequence s_req; (avs_read || avs_write) && avs_waitrequest && ce; endsequence
  sequence s_rd_spd; avs_read && avs_address == 8'hEC && avs_waitrequest; endsequence
  sequence s_rd_none; avs_read && avs_address == 8'h00 && avs_waitrequest; endsequence
  AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RD_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_RD_HOLD: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved between answers");
  AST_SPEED_RST: assert property (s_rd_spd ##1 (!avs_waitrequest && !wr_r) |-> avs_readdata[7:0] == 8'h7A)
    else $error("speed register not at its reset value");
  AST_SPEED_ECHO: assert property (s_rd_spd ##1 (!avs_waitrequest && wr_r) |-> avs_readdata[7:0] == spd_r)
    else $error("speed register lost its written value");
  AST_UNMAPPED: assert property (s_rd_none ##1 !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_TX_LOW_RUN: assert property (!txd_r |-> low_r <= 9 * per + per / OVS + 2)
    else $error("serial output low longer than one character allows");
  AST_CE_FREEZE: assert property (!ce |=> $stable(txd_r) && $stable(avs_waitrequest))
    else $error("outputs moved while clock enable was low");
endmodule // hubg_props
bind hubg_uart hubg_props #(.OVS(OVS)) u_props (.clk(clk), .rstn(rstn), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd_r(txd_r));
`default_nettype wire

// ==== dv/hubg_tb.sv ====
// self-checking bench for the host uart
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic        clk = 1'b0;            // 40 mhz clock
  logic        rstn = 1'b0;           // reset, active low
  logic        ce = 1'b1;             // enable, on except in the hold test
  logic [7:0]  avs_address = 8'h00;   // bus address
  logic        avs_read = 1'b0;       // read strobe
  logic        avs_write = 1'b0;      // write strobe
  logic [31:0] avs_writedata = 32'h0; // write data
  logic [31:0] avs_readdata;          // read data
  logic        avs_waitrequest;       // stall
  logic        rxd;                   // host to device
  logic        txd_r;                 // device to host
  logic [31:0] q;                     // last read value
  int          bad_count = 0;         // mismatches
  int          check_count = 0;       // comparisons
  int          cyc = 0;               // watchdog count
  logic [7:0]  spd_t [6] = '{8'h15, 8'h1C, 8'h3A, 8'h5A, 8'h7A, 8'hFA}; // all at or below 1232.7k
  always #12.5 clk = ~clk;
  hubg_uart #(.OVS(16)) dut (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd_r(txd_r));
  hubg_host_model host (.txd(txd_r), .rxd(rxd));
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // bit time in ns from the crystal divider
  function automatic real per_ns(input logic [7:0] s);
    int dv;
    dv = (s[7:5] == 3'h0) ? s[4:0] + 1 : (s[4:0] + 33) << (s[7:5] - 1);
    return dv * 1000.0 / 27.12;
  endfunction
  task automatic t_regs;
    bus(1'b0, 8'hEC, 32'h0);
    `CHK(q, 32'h7A)
    bus(1'b1, 8'h00, 32'hFF);
    bus(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h0)
    foreach (spd_t[i]) begin
      bus(1'b1, 8'hEC, {24'h0, spd_t[i]});
      bus(1'b0, 8'hEC, 32'h0);
      `CHK(q, {24'h0, spd_t[i]})
    end
    $display("test regs done");
  endtask
  // a zero character checks the rate, a mixed one the bit order
  task automatic t_tx(input logic [7:0] s);
    real t, lo, tf;
    logic [7:0] d;
    logic st;
    t = per_ns(s);
    bus(1'b1, 8'hEC, {24'h0, s});
    fork host.recv(t, d, st); bus(1'b1, 8'hF0, 32'h0); join
    lo = host.t_rise - host.t_fall;
    tf = host.t_fall;
    `CHK((lo > 9 * t - t / 16 - 60 && lo < 9 * t + t / 16 + 60), 1'b1)
    `CHK({d, st}, 9'h001)
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q[0], 1'b1)
    // a write while busy must be dropped: no new start edge may follow
    bus(1'b1, 8'hF0, 32'hFF);
    do bus(1'b0, 8'hF4, 32'h0); while (q[0] !== 1'b0);
    `CHK((host.t_fall == tf), 1'b1)
    fork host.recv(t, d, st); bus(1'b1, 8'hF0, 32'hA5); join
    `CHK({d, st}, 9'h14B)
    do bus(1'b0, 8'hF4, 32'h0); while (q[0] !== 1'b0);
    $display("test tx %0h done", s);
  endtask
  // receive one character, with a good or a broken stop bit, then two more to force an overrun
  task automatic t_rx(input logic [7:0] s, input logic [7:0] v, input logic stp);
    bus(1'b1, 8'hEC, {24'h0, s});
    host.send(v, stp, per_ns(s));
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q[3:1], {~stp, 2'b01})
    bus(1'b0, 8'hF0, 32'h0);
    `CHK(q, {24'h0, v})
    host.send(~v, 1'b1, per_ns(s));
    host.send(v, 1'b1, per_ns(s));
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q[3:1], {~stp, 2'b11})
    bus(1'b0, 8'hF0, 32'h0);
    `CHK(q, {24'h0, v})
    bus(1'b1, 8'hF4, 32'hC);
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q[3:1], 3'b000)
    $display("test rx %0h done", s);
  endtask
  // clock enable low must hold a character in flight
  task automatic t_hold;
    bus(1'b1, 8'hEC, 32'h15);
    bus(1'b1, 8'hF0, 32'h0);
    ce <= 1'b0;
    repeat (400) @(posedge clk);
    `CHK(txd_r, 1'b0)
    ce <= 1'b1;
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q[0], 1'b1)
    do bus(1'b0, 8'hF4, 32'h0); while (q[0] !== 1'b0);
    $display("test hold done");
  endtask
  // reset in mid-run: the speed setting must fall back to its default
  task automatic t_reset;
    bus(1'b1, 8'hEC, 32'h3A);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 8'hEC, 32'h0);
    `CHK(q, 32'h7A)
    bus(1'b0, 8'hF4, 32'h0);
    `CHK(q, 32'h0)
    $display("test reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_tx(8'h7A);
    t_tx(8'h15);
    t_tx(8'h3A);
    t_rx(8'h15, 8'h3C, 1'b1);
    t_rx(8'h3A, 8'h81, 1'b0);
    t_hold();
    t_reset();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
